// ---- core/usb_csr_map.vh ----
// Register map, field positions and reset values of the USB control block.
// Included by the design files only; definitions only.
`ifndef USB_CSR_MAP_VH
`define USB_CSR_MAP_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define CSR0_OFS 12'h000
`define CSR1_OFS 12'h004
`define CSR2_OFS 12'h008

// ----------------------------------------------------------------
// Control/status word 0
// ----------------------------------------------------------------
`define TXF_HI 23
`define TXF_LO 17
`define EP0F_BIT 16
`define ISO_BIT 15
`define SOFTC_BIT 14
`define HI_SPEED_ENABLE_BIT 13
`define HSST_BIT 12
`define RST_BIT 11
`define RSM_BIT 10
`define SUSST_BIT 9
`define SUSEN_BIT 8
`define FADDR_HI 6
`define FADDR_LO 0

// ----------------------------------------------------------------
// Word 1: transmit enables, receive flags
// ----------------------------------------------------------------
`define TXE_HI 23
`define TXE_LO 17
`define EP0E_BIT 16
`define RXF_HI 7
`define RXF_LO 1

// ----------------------------------------------------------------
// Word 2: bus event enables and flags, receive enables
// ----------------------------------------------------------------
`define BUSE_HI 31
`define BUSE_LO 24
`define BUSF_HI 23
`define BUSF_LO 16
`define RXE_HI 7
`define RXE_LO 1

// Bus event index inside the enable and flag bytes
`define EV_VBUS 7
`define EV_SESS 6
`define EV_DISC 5
`define EV_CONN 4
`define EV_SOF 3
`define EV_RSTB 2
`define EV_RSM 1
`define EV_SUSP 0

// ----------------------------------------------------------------
// Reset values and bus answers
// ----------------------------------------------------------------
`define TXE_RST 7'h7F
`define EP0E_RST 1'h0
`define BUSE_RST 8'h06
`define RXE_RST 7'h7F
`define HI_SPEED_ENABLE_RST 1'h1
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ---- core/sync_2ff.v ----
// Two-flop synchroniser for a bundle of unrelated level inputs.
// Assumes each bit is a slow level from a pin; no bus coherency is kept.
`timescale 1ns/1ps
module sync_2ff #(
    parameter WIDTH = 6
) (
    // Clock, reset, enable
    input wire aclk,
    input wire aresetn,
    input wire ce,
    // Levels
    input wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);

reg [WIDTH-1:0] meta_reg;
reg [WIDTH-1:0] sync_reg;

// First stage feeds only the second
always @(posedge aclk) begin
    if (!aresetn) begin
        meta_reg <= {WIDTH{1'b0}};
        sync_reg <= {WIDTH{1'b0}};
    end else if (ce) begin
        meta_reg <= async_in;
        sync_reg <= meta_reg;
    end
end

assign sync_out = sync_reg;

endmodule

// ---- core/usb_top_control_status.v ----
// Top control and status logic of a dual-role USB controller, AXI4-Lite slave.
// Assumes link engine signals on aclk; line levels arrive from pins unsynchronised.
//
// What this block does
// - Set endpoint 1-7 transmit flags, bits 23-17, on transmit events.
// - Set endpoint 0 flag, bit 16, on any control endpoint event.
// - Reading word 0 clears the transmit flags and endpoint 0 flag.
// - Device iso update bit 15: iso packet waits for next SOF after ready.
// - Device soft connect bit 14 enables D+/D- drivers, else tri-state.
// - Hi-speed enable bit 13 allows hi-speed negotiation in bus reset.
// - Bit 12 shows hi-speed success, valid after reset ends.
// - Bit 11 shows bus reset; host software writes it to drive reset.
// - Resume bit 10 drives resume while suspended; clearing stops it.
// - Bit 9 shows suspend; host software sets it, hardware clears it.
// - Bit 8 allows suspend entry when set, prevents it when clear.
// - Device function address bits 6-0 match later token addresses.
// - Transmit enables 23-17 reset to one; endpoint 0 enable resets zero.
// - Set receive flags, word 1 bits 7-1, on receive events.
// - Word 2 bits 31-24 enable the eight bus event flags.
// - Set VBUS error flag, bit 23, when VBUS drops during a session.
// - Set session request flag, bit 22, on session request signaling.
// - Set disconnect flag, bit 21: host disconnect or device session end.
// - Host mode: set connection flag, bit 20, on peripheral connect.
// - Set reset/babble flag on host babble or device bus reset.
`timescale 1ns/1ps
`include "usb_csr_map.vh"
module usb_top_control_status #(
    parameter ADDR_W = 12,
    parameter NUM_EP = 7
) (
    // Clock, reset, enable
    input wire aclk,
    input wire aresetn,
    input wire ce,
    // AXI4-Lite write address and data
    input wire [ADDR_W-1:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    // AXI4-Lite write response
    output wire [1:0] s_axi_bresp,
    output wire s_axi_bvalid,
    input wire s_axi_bready,
    // AXI4-Lite read
    input wire [ADDR_W-1:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0] s_axi_rresp,
    output wire s_axi_rvalid,
    input wire s_axi_rready,
    // Line levels from pins
    input wire vbus_valid,
    input wire line_reset,
    input wire line_suspend,
    input wire line_resume,
    input wire line_attach,
    input wire session_request_line,
    // Link engine, same clock
    input wire host_mode,
    input wire session_active,
    input wire endpoint_zero_event,
    input wire [NUM_EP:1] endpoint_tx_event,
    input wire [NUM_EP:1] endpoint_rx_event,
    input wire sof_token,
    input wire babble_detect,
    input wire hs_handshake_ok,
    input wire tx_packet_ready,
    input wire iso_endpoint,
    input wire token_valid,
    input wire [6:0] token_addr,
    // Line control and status
    output wire line_drive_oe_n,
    output wire hi_speed_enable,
    output wire bus_reset_drive,
    output wire resume_drive,
    output wire suspend_status,
    output wire iso_send_go,
    output wire token_addr_match,
    output wire irq
);

// ----------------------------------------------------------------
// Address decode
// ----------------------------------------------------------------
function hit;
    input [ADDR_W-1:0] addr;
    input [ADDR_W-1:0] ofs;
    hit = (addr[ADDR_W-1:2] == ofs[ADDR_W-1:2]);
endfunction
// ----------------------------------------------------------------
// State
// ----------------------------------------------------------------
reg [NUM_EP:1] tx_flag_reg, rx_flag_reg, tx_en_reg, rx_en_reg;
reg [7:0] bus_flag_reg, bus_en_reg;
reg ep0_flag_reg, ep0_en_reg, iso_wait_frame_reg, soft_connect_reg, hi_speed_enable_reg;
reg hi_speed_status_reg, host_reset_reg, resume_reg, suspend_status_reg, suspend_enable_reg;
reg [6:0] function_address_reg;
reg iso_pending_reg, iso_go_reg, match_reg, irq_reg, oe_n_reg, resume_drive_reg;
reg pkt_rdy_prev_reg, sess_prev_reg, aw_held_reg, w_held_reg, bvalid_reg, rvalid_reg;
reg [5:0] prev_reg;
reg [ADDR_W-1:0] awaddr_reg;
reg [31:0] wdata_reg, rdata_reg;
reg [3:0] wstrb_reg;
reg [1:0] bresp_reg, rresp_reg;
wire [5:0] line_s;
wire vbus_s = line_s[0];
wire reset_s = line_s[1];
wire susp_s = line_s[2];
wire rsm_s = line_s[3];
wire attach_s = line_s[4];
wire srp_s = line_s[5];
// Pin levels cross in through two flops
sync_2ff #(.WIDTH(6)) line_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .async_in({session_request_line, line_attach, line_resume, line_suspend,
        line_reset, vbus_valid}),
    .sync_out(line_s)
);
// ----------------------------------------------------------------
// Bus events from synchronised levels and link engine inputs
// ----------------------------------------------------------------
wire reset_rise = reset_s & ~prev_reg[1];
wire reset_fall = ~reset_s & prev_reg[1];
wire susp_rise = susp_s & ~prev_reg[2];
wire rsm_rise = rsm_s & ~prev_reg[3];
wire attach_rise = attach_s & ~prev_reg[4];
wire attach_fall = ~attach_s & prev_reg[4];
wire [7:0] bus_evt;
assign bus_evt[`EV_VBUS] = session_active & prev_reg[0] & ~vbus_s;
assign bus_evt[`EV_SESS] = srp_s & ~prev_reg[5];
assign bus_evt[`EV_DISC] = host_mode ? attach_fall : (sess_prev_reg & ~session_active);
assign bus_evt[`EV_CONN] = host_mode & attach_rise;
assign bus_evt[`EV_SOF] = sof_token;
assign bus_evt[`EV_RSTB] = host_mode ? babble_detect : reset_rise;
assign bus_evt[`EV_RSM] = suspend_status_reg & rsm_rise;
assign bus_evt[`EV_SUSP] = ~host_mode & susp_rise;
// ----------------------------------------------------------------
// AXI4-Lite handshakes
// ----------------------------------------------------------------
assign s_axi_awready = ce & ~aw_held_reg & ~bvalid_reg;
assign s_axi_wready = ce & ~w_held_reg & ~bvalid_reg;
assign s_axi_arready = ce & ~rvalid_reg;
wire aw_hs = s_axi_awvalid & s_axi_awready;
wire w_hs = s_axi_wvalid & s_axi_wready;
wire ar_hs = s_axi_arvalid & s_axi_arready;
wire [ADDR_W-1:0] wr_addr = aw_held_reg ? awaddr_reg : s_axi_awaddr;
wire [31:0] wr_data = w_held_reg ? wdata_reg : s_axi_wdata;
wire [3:0] wr_strb = w_held_reg ? wstrb_reg : s_axi_wstrb;
wire do_write = (aw_held_reg | aw_hs) & (w_held_reg | w_hs) & ~bvalid_reg & ce;
wire wr0 = do_write & hit(wr_addr, `CSR0_OFS);
wire wr1 = do_write & hit(wr_addr, `CSR1_OFS);
wire wr2 = do_write & hit(wr_addr, `CSR2_OFS);
wire wr_map = wr0 | wr1 | wr2;
wire rd0 = ar_hs & hit(s_axi_araddr, `CSR0_OFS);
wire rd1 = ar_hs & hit(s_axi_araddr, `CSR1_OFS);
wire rd2 = ar_hs & hit(s_axi_araddr, `CSR2_OFS);
// Reset bit reads the line in device mode, the drive request in host mode
wire reset_view = host_mode ? host_reset_reg : reset_s;
// ----------------------------------------------------------------
// Read word assembly
// ----------------------------------------------------------------
reg [31:0] word0, word1, word2;
always @* begin
    word0 = 32'h0000_0000;
    word0[`TXF_HI:`TXF_LO] = tx_flag_reg;
    word0[`EP0F_BIT] = ep0_flag_reg;
    word0[`ISO_BIT] = iso_wait_frame_reg & ~host_mode;
    word0[`SOFTC_BIT] = soft_connect_reg;
    word0[`HI_SPEED_ENABLE_BIT] = hi_speed_enable_reg;
    word0[`HSST_BIT] = hi_speed_status_reg;
    word0[`RST_BIT] = reset_view;
    word0[`RSM_BIT] = resume_reg;
    word0[`SUSST_BIT] = suspend_status_reg;
    word0[`SUSEN_BIT] = suspend_enable_reg;
    word0[`FADDR_HI:`FADDR_LO] = function_address_reg;
    word1 = 32'h0000_0000;
    word1[`TXE_HI:`TXE_LO] = tx_en_reg;
    word1[`EP0E_BIT] = ep0_en_reg;
    word1[`RXF_HI:`RXF_LO] = rx_flag_reg;
    word2 = 32'h0000_0000;
    word2[`BUSE_HI:`BUSE_LO] = bus_en_reg;
    word2[`BUSF_HI:`BUSF_LO] = bus_flag_reg;
    word2[`RXE_HI:`RXE_LO] = rx_en_reg;
end
// ----------------------------------------------------------------
// Event flags: set wins over clear-on-read
// ----------------------------------------------------------------
genvar i;
generate
    for (i = 1; i <= NUM_EP; i = i + 1) begin : ep_flags
        always @(posedge aclk) begin
            if (!aresetn) begin
                {tx_flag_reg[i], rx_flag_reg[i]} <= 2'b00;
            end else if (ce) begin
                tx_flag_reg[i] <= (tx_flag_reg[i] & ~rd0) | endpoint_tx_event[i];
                rx_flag_reg[i] <= (rx_flag_reg[i] & ~rd1) | endpoint_rx_event[i];
            end
        end
    end
    for (i = 0; i < 8; i = i + 1) begin : bus_flags
        always @(posedge aclk) begin
            if (!aresetn) begin
                bus_flag_reg[i] <= 1'b0;
            end else if (ce) begin
                bus_flag_reg[i] <= (bus_flag_reg[i] & ~rd2) | bus_evt[i];
            end
        end
    end
endgenerate
// ----------------------------------------------------------------
// Software controls; byte lanes honoured
// ----------------------------------------------------------------
always @(posedge aclk) begin
    if (!aresetn) begin
        {iso_wait_frame_reg, soft_connect_reg, host_reset_reg, resume_reg} <= 4'h0;
        {suspend_enable_reg, function_address_reg} <= 8'h00;
        hi_speed_enable_reg <= `HI_SPEED_ENABLE_RST;
        tx_en_reg <= `TXE_RST;
        ep0_en_reg <= `EP0E_RST;
        bus_en_reg <= `BUSE_RST;
        rx_en_reg <= `RXE_RST;
    end else if (ce) begin
        if (wr0 & wr_strb[1]) begin
            // Iso update exists only in device mode, reset drive only in host mode
            iso_wait_frame_reg <= host_mode ? iso_wait_frame_reg : wr_data[`ISO_BIT];
            soft_connect_reg <= wr_data[`SOFTC_BIT];
            hi_speed_enable_reg <= wr_data[`HI_SPEED_ENABLE_BIT];
            host_reset_reg <= host_mode ? wr_data[`RST_BIT] : host_reset_reg;
            resume_reg <= wr_data[`RSM_BIT];
            suspend_enable_reg <= wr_data[`SUSEN_BIT];
        end
        if (wr0 & wr_strb[0]) begin
            function_address_reg <= wr_data[`FADDR_HI:`FADDR_LO];
        end
        if (wr1 & wr_strb[2]) begin
            {tx_en_reg, ep0_en_reg} <= wr_data[`TXE_HI:`EP0E_BIT];
        end
        if (wr2 & wr_strb[3]) begin
            bus_en_reg <= wr_data[`BUSE_HI:`BUSE_LO];
        end
        if (wr2 & wr_strb[0]) begin
            rx_en_reg <= wr_data[`RXE_HI:`RXE_LO];
        end
    end
end
// ----------------------------------------------------------------
// Suspend, hi-speed status, line edge history
// ----------------------------------------------------------------
wire host_rst_fall = wr0 & wr_strb[1] & host_mode & host_reset_reg & ~wr_data[`RST_BIT];
wire resume_end = wr0 & wr_strb[1] & resume_reg & ~wr_data[`RSM_BIT];
wire host_susp_set = wr0 & wr_strb[1] & host_mode & wr_data[`SUSST_BIT];
always @(posedge aclk) begin
    if (!aresetn) begin
        {suspend_status_reg, hi_speed_status_reg, sess_prev_reg, ep0_flag_reg} <= 4'h0;
        prev_reg <= 6'h00;
    end else if (ce) begin
        prev_reg <= line_s;
        sess_prev_reg <= session_active;
        // Endpoint 0 flag shares the clear-on-read byte; set wins
        ep0_flag_reg <= (ep0_flag_reg & ~rd0) | endpoint_zero_event;
        // Wake-up wins over entry so a resume is never swallowed
        if (bus_evt[`EV_RSM] | reset_rise | resume_end) begin
            suspend_status_reg <= 1'b0;
        end else if (suspend_enable_reg & (host_mode ? host_susp_set : susp_rise)) begin
            suspend_status_reg <= 1'b1;
        end
        // Latched when the reset ends; hi-speed only if enabled
        if (host_mode ? host_rst_fall : reset_fall) begin
            hi_speed_status_reg <= hi_speed_enable_reg & hs_handshake_ok;
        end else if (!host_mode & reset_rise) begin
            hi_speed_status_reg <= 1'b0;
        end
    end
end
// ----------------------------------------------------------------
// Iso gating, token address match, line outputs, interrupt
// ----------------------------------------------------------------
wire pkt_rdy_rise = tx_packet_ready & ~pkt_rdy_prev_reg;
wire iso_hold = iso_wait_frame_reg & ~host_mode & iso_endpoint;
wire [NUM_EP:0] pend = {tx_flag_reg & tx_en_reg, ep0_flag_reg & ep0_en_reg};
wire any_irq = (|pend) | (|(rx_flag_reg & rx_en_reg)) | (|(bus_flag_reg & bus_en_reg));
always @(posedge aclk) begin
    if (!aresetn) begin
        {pkt_rdy_prev_reg, iso_pending_reg, iso_go_reg, match_reg} <= 4'h0;
        {irq_reg, resume_drive_reg} <= 2'h0;
        oe_n_reg <= 1'b1;
    end else if (ce) begin
        pkt_rdy_prev_reg <= tx_packet_ready;
        // Held packet leaves on the next SOF; ready dropping cancels it
        if (iso_pending_reg & (sof_token | ~tx_packet_ready)) begin
            iso_pending_reg <= 1'b0;
        end else if (pkt_rdy_rise & iso_hold) begin
            iso_pending_reg <= 1'b1;
        end
        iso_go_reg <= (pkt_rdy_rise & ~iso_hold) |
            (iso_pending_reg & sof_token & tx_packet_ready);
        match_reg <= token_valid & ~host_mode & (token_addr == function_address_reg);
        irq_reg <= any_irq;
        oe_n_reg <= ~(host_mode | soft_connect_reg);
        resume_drive_reg <= resume_reg & suspend_status_reg;
    end
end
// ----------------------------------------------------------------
// AXI4-Lite channel state
// ----------------------------------------------------------------
always @(posedge aclk) begin
    if (!aresetn) begin
        {aw_held_reg, w_held_reg, bvalid_reg, rvalid_reg} <= 4'h0;
        awaddr_reg <= {ADDR_W{1'b0}};
        {wdata_reg, rdata_reg} <= 64'h0;
        wstrb_reg <= 4'h0;
        {bresp_reg, rresp_reg} <= {`RESP_OKAY, `RESP_OKAY};
    end else if (ce) begin
        // Park whichever half arrives first
        if (do_write) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            bvalid_reg <= 1'b1;
            bresp_reg <= wr_map ? `RESP_OKAY : `RESP_SLVERR;
        end else begin
            if (aw_hs) begin
                aw_held_reg <= 1'b1;
                awaddr_reg <= s_axi_awaddr;
            end
            if (w_hs) begin
                w_held_reg <= 1'b1;
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end
            bvalid_reg <= bvalid_reg & ~s_axi_bready;
        end
        // Snapshot taken in the cycle the flags clear, so none is lost
        if (ar_hs) begin
            rvalid_reg <= 1'b1;
            rdata_reg <= rd0 ? word0 : (rd1 ? word1 : (rd2 ? word2 : 32'h0000_0000));
            rresp_reg <= (rd0 | rd1 | rd2) ? `RESP_OKAY : `RESP_SLVERR;
        end else if (rvalid_reg & s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end
end
// ----------------------------------------------------------------
// Outputs
// ----------------------------------------------------------------
assign s_axi_bvalid = bvalid_reg;
assign s_axi_bresp = bresp_reg;
assign s_axi_rvalid = rvalid_reg;
assign s_axi_rdata = rdata_reg;
assign s_axi_rresp = rresp_reg;
assign line_drive_oe_n = oe_n_reg;
assign hi_speed_enable = hi_speed_enable_reg;
assign bus_reset_drive = host_reset_reg;
assign resume_drive = resume_drive_reg;
assign suspend_status = suspend_status_reg;
assign iso_send_go = iso_go_reg;
assign token_addr_match = match_reg;
assign irq = irq_reg;
endmodule

// ---- sim/usb_link_partner.sv ----
// Bus partner model: drives the line levels that the block sees from its pins.
// Assumes the bench calls set_pins; levels move just after a rising clock edge.
`timescale 1ns/1ps
module usb_link_partner (
    // Clock
    input wire aclk,
    // Line levels, active high
    output reg vbus_valid,
    output reg line_reset,
    output reg line_suspend,
    output reg line_resume,
    output reg line_attach,
    output reg session_request_line
);
    // -------------------------------------------
    // Levels: powered bus, nothing else at start
    // -------------------------------------------
    initial begin
        {vbus_valid, line_reset, line_suspend} = 3'h4;
        {line_resume, line_attach, session_request_line} = 3'h0;
    end

    // Order: vbus, reset, suspend, resume, attach, session request
    task set_pins(input [5:0] v);
        begin
            @(posedge aclk);
            {vbus_valid, line_reset, line_suspend} <= v[5:3];
            {line_resume, line_attach, session_request_line} <= v[2:0];
        end
    endtask
endmodule

// ---- sim/usb_top_control_status_assertions.sv ----
// Port checker for the USB top control block, bound into the design.
// Assumes one clock aclk, ce held high, synchronous active-low aresetn.
`timescale 1ns/1ps
module usb_csr_checker #(
    parameter NUM_EP = 7
) (
    // Clock, reset
    input wire aclk,
    input wire aresetn,
    // Read channel
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire [31:0] s_axi_rdata,
    // Write channel
    input wire s_axi_awready,
    input wire s_axi_wready,
    input wire s_axi_bvalid,
    // Link side
    input wire host_mode,
    input wire [NUM_EP:1] endpoint_tx_event,
    input wire tx_packet_ready,
    input wire token_valid,
    // Outputs watched
    input wire line_drive_oe_n,
    input wire resume_drive,
    input wire suspend_status,
    input wire iso_send_go,
    input wire token_addr_match,
    input wire irq
);
    // ------------------------------
    // Properties
    // ------------------------------
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("late read answer");
    a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data unstable");
    a_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while busy");
    a_host_drivers: assert property ($past(host_mode) && $past(aresetn) |-> !line_drive_oe_n)
        else $error("host drivers off");
    a_resume_gate: assert property (resume_drive |-> $past(suspend_status))
        else $error("resume while awake");
    a_iso_go: assert property (iso_send_go |-> $past(tx_packet_ready))
        else $error("send without ready");
    a_token_match: assert property (token_addr_match |-> $past(token_valid))
        else $error("match without token");
    a_irq_raise: assert property (endpoint_tx_event[1] |-> ##[1:2] irq)
        else $error("no irq for event");
endmodule

bind usb_top_control_status usb_csr_checker #(.NUM_EP(NUM_EP)) i_usb_csr_checker (.*);

// ---- sim/usb_top_control_status_tb.sv ----
// Bench for the USB top control block: AXI4-Lite tasks and register scenarios.
// Assumes the bound checker and the bus partner model; ce stays high.
`timescale 1ns/1ps
module usb_top_control_status_tb;
    // ------------------------------
    // Signals
    // ------------------------------
    reg aclk = 0, aresetn = 0, ce = 1;
    reg [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    reg [2:0] s_axi_awprot = 0, s_axi_arprot = 0;
    reg s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    reg s_axi_arvalid = 0, s_axi_rready = 0;
    reg [31:0] s_axi_wdata = 0, rd;
    reg [3:0] s_axi_wstrb = 0;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire vbus_valid, line_reset, line_suspend, line_resume, line_attach, session_request_line;
    reg host_mode = 0, session_active = 0, endpoint_zero_event = 0, sof_token = 0;
    reg babble_detect = 0, hs_handshake_ok = 1, tx_packet_ready = 0, iso_endpoint = 0;
    reg token_valid = 0, go_seen = 0;
    reg [6:0] token_addr = 0;
    reg [7:1] endpoint_tx_event = 0, endpoint_rx_event = 0;
    wire line_drive_oe_n, hi_speed_enable, bus_reset_drive, resume_drive, suspend_status;
    wire iso_send_go, token_addr_match, irq;
    reg [1:0] rsp;
    integer err_total = 0, cmp_count = 0;

    always #12.5 aclk = ~aclk;
    usb_top_control_status i_usb_top_control_status (.*);
    usb_link_partner i_usb_link_partner (.*);
    // Sticky: the send pulse lasts one cycle only
    always @(posedge aclk) if (iso_send_go) go_seen <= 1'h1;

    // ------------------------------
    // Tasks
    // ------------------------------
    task chk(input [31:0] got, input [31:0] exp);
        begin
            cmp_count = cmp_count + 1;
            if (got !== exp) begin
                err_total = err_total + 1;
                $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask

    task cyc(input integer n);
        repeat (n) @(posedge aclk);
    endtask

    // Sampled at negedge; the next rising edge is the handshake
    task wr(input [11:0] a, input [31:0] d, input [3:0] s, input [1:0] er);
        reg ta, tw, tb;
        begin
            @(posedge aclk);
            {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, s};
            {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
            tb = 0;
            while (!tb) begin
                @(negedge aclk);
                ta = s_axi_awvalid & s_axi_awready;
                tw = s_axi_wvalid & s_axi_wready;
                tb = s_axi_bvalid;
                rsp = s_axi_bresp;
                @(posedge aclk);
                if (ta) s_axi_awvalid <= 1'h0;
                if (tw) s_axi_wvalid <= 1'h0;
            end
            s_axi_bready <= 1'h0;
            chk(rsp, er);
        end
    endtask

    task rdc(input [11:0] a, input [31:0] exp, input [1:0] er);
        reg ta, tr;
        begin
            @(posedge aclk);
            {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
            tr = 0;
            while (!tr) begin
                @(negedge aclk);
                ta = s_axi_arvalid & s_axi_arready;
                tr = s_axi_rvalid;
                rd = s_axi_rdata;
                rsp = s_axi_rresp;
                @(posedge aclk);
                if (ta) s_axi_arvalid <= 1'h0;
            end
            s_axi_rready <= 1'h0;
            chk(rd, exp);
            chk(rsp, er);
        end
    endtask

    task tok(input [6:0] a, input [31:0] e);
        begin
            @(posedge aclk);
            {token_valid, token_addr} <= {1'h1, a};
            @(posedge aclk);
            token_valid <= 1'h0;
            @(negedge aclk);
            chk(token_addr_match, e);
        end
    endtask

    task stop_test;
        begin
            $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
            if (err_total == 0 && cmp_count > 0) $display("Regression OK");
            else $display("Regression broken");
            $finish;
        end
    endtask

    // ------------------------------
    // Scenarios
    // ------------------------------
    initial begin
        cyc(5);
        aresetn <= 1'h1;
        rdc(12'h000, 32'h0000_2000, 2'h0);
        rdc(12'h004, 32'h00FE_0000, 2'h0);
        rdc(12'h008, 32'h0600_00FE, 2'h0);
        rdc(12'h00C, 32'h0, 2'h2);
        wr(12'h00C, 32'hFFFF_FFFF, 4'hF, 2'h2);
        @(posedge aclk);
        {endpoint_tx_event, endpoint_rx_event, endpoint_zero_event} <= 15'h7FFF;
        @(posedge aclk);
        {endpoint_tx_event, endpoint_rx_event, endpoint_zero_event} <= 15'h0;
        cyc(2);
        chk(irq, 32'h1);
        rdc(12'h000, 32'h00FF_2000, 2'h0);
        rdc(12'h000, 32'h0000_2000, 2'h0);
        rdc(12'h004, 32'h00FE_00FE, 2'h0);
        cyc(2);
        chk(irq, 32'h0);
        // Endpoint 2 masked: flag sets, irq stays quiet
        wr(12'h004, 32'h00FA_0000, 4'h4, 2'h0);
        endpoint_tx_event <= 7'h02;
        @(posedge aclk);
        endpoint_tx_event <= 7'h00;
        cyc(3);
        chk(irq, 32'h0);
        rdc(12'h000, 32'h0004_2000, 2'h0);
        wr(12'h000, 32'h0000_602A, 4'h3, 2'h0);
        rdc(12'h000, 32'h0000_602A, 2'h0);
        chk(line_drive_oe_n, 32'h0);
        tok(7'h2A, 32'h1);
        tok(7'h2B, 32'h0);
        // Bus events with every enable set
        wr(12'h008, 32'hFF00_00FE, 4'hF, 2'h0);
        session_active <= 1'h1;
        cyc(2);
        i_usb_link_partner.set_pins(6'h00);
        cyc(6);
        i_usb_link_partner.set_pins(6'h01);
        session_active <= 1'h0;
        cyc(6);
        host_mode <= 1'h1;
        i_usb_link_partner.set_pins(6'h03);
        babble_detect <= 1'h1;
        @(posedge aclk);
        babble_detect <= 1'h0;
        cyc(6);
        rdc(12'h008, 32'hFFF4_00FE, 2'h0);
        rdc(12'h008, 32'hFF00_00FE, 2'h0);
        // Host reset, then suspend and resume
        wr(12'h000, 32'h0000_2800, 4'h2, 2'h0);
        chk(bus_reset_drive, 32'h1);
        wr(12'h000, 32'h0000_2000, 4'h2, 2'h0);
        rdc(12'h000, 32'h0000_302A, 2'h0);
        wr(12'h000, 32'h0000_2200, 4'h2, 2'h0);
        chk(suspend_status, 32'h0);
        wr(12'h000, 32'h0000_2100, 4'h2, 2'h0);
        wr(12'h000, 32'h0000_2300, 4'h2, 2'h0);
        chk(suspend_status, 32'h1);
        wr(12'h000, 32'h0000_2700, 4'h2, 2'h0);
        cyc(2);
        chk(resume_drive, 32'h1);
        wr(12'h000, 32'h0000_2300, 4'h2, 2'h0);
        cyc(2);
        chk({30'h0, resume_drive, suspend_status}, 32'h0);
        // Device iso endpoint holds its packet until a frame start
        host_mode <= 1'h0;
        wr(12'h000, 32'h0000_A000, 4'h2, 2'h0);
        iso_endpoint <= 1'h1;
        tx_packet_ready <= 1'h1;
        cyc(4);
        chk(go_seen, 32'h0);
        sof_token <= 1'h1;
        @(posedge aclk);
        sof_token <= 1'h0;
        cyc(3);
        chk(go_seen, 32'h1);
        stop_test;
    end

    // Hang guard, far beyond the hundred-odd cycles needed
    initial begin
        repeat (20000) @(posedge aclk);
        err_total = err_total + 1;
        stop_test;
    end
endmodule
